// *** garc_pkg.sv ***
// package: register map, field layout and timing for the relay control block
package garc_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;

  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_SW_CFG   = 0;
  localparam int unsigned CTRL_LATCH    = 1;
  localparam int unsigned CTRL_NC       = 2;
  localparam int unsigned CTRL_COF      = 3;
  localparam int unsigned CTRL_CLEAR    = 4;
  localparam int unsigned CTRL_W        = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // status register fields
  localparam int unsigned ST_LOW_ALM    = 0;
  localparam int unsigned ST_HIGH_ALM   = 1;
  localparam int unsigned ST_FAULT      = 2;
  localparam int unsigned ST_LOW_K      = 3;
  localparam int unsigned ST_HIGH_K     = 4;
  localparam int unsigned ST_FAULT_K    = 5;
  localparam int unsigned ST_LATCH      = 6;
  localparam int unsigned ST_NC         = 7;
  localparam int unsigned ST_COF        = 8;
  localparam int unsigned ST_MAG        = 9;
  localparam int unsigned ST_GAS        = 12;
  localparam int unsigned ST_W          = 15;

  // interrupt event bits
  localparam int unsigned EV_LOW        = 0;
  localparam int unsigned EV_HIGH       = 1;
  localparam int unsigned EV_FAULT      = 2;
  localparam int unsigned EV_CLEAR      = 3;
  localparam int unsigned EV_W          = 4;
  localparam logic [EV_W-1:0] EV_RST    = 4'h0;

  // synchronised pin bundle
  typedef struct packed {
    logic       low_trip;
    logic       high_trip;
    logic       fault_in;
    logic       alarm_nc_sel;
    logic       fault_open_sel;
    logic       fault_closed_sel;
    logic       low_latch_sw;
    logic [2:0] gas_sel;
    logic       fixed_factory_jumper;
  } garc_pins_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } garc_apb_rsp_s;

  typedef struct packed {
    logic low;
    logic high;
    logic fault;
  } garc_relay_s;

endpackage : garc_pkg

// *** garc_debounce.sv ***
// debouncer: two-stage synchroniser, stable-time filter, press pulse
module garc_debounce
  import garc_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  output logic      level,
  output logic      press
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  initial
  begin
    if (STABLE_CYC < 1)
      $error("garc_debounce: STABLE_CYC must be at least 1");
  end

  typedef struct packed {
    logic          meta;
    logic          sync;
    logic          level;
    logic          press;
    logic [CW-1:0] cnt;
  } garc_db_s;

  garc_db_s q;
  garc_db_s next_q;

  always_comb
  begin
    next_q       = q;
    next_q.meta  = raw_in;
    next_q.sync  = q.meta;
    next_q.press = 1'b0;
    if (q.sync == q.level)
      next_q.cnt = '0;
    else if (q.cnt == CW'(STABLE_CYC - 1))
    begin
      next_q.cnt   = '0;
      next_q.level = q.sync;
      next_q.press = q.sync;
    end
    else
      next_q.cnt = q.cnt + CW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= next_q;
  end

  assign level = q.level;
  assign press = q.press;

endmodule // garc_debounce

// *** garc_relay_ctrl.sv ***
// gas alarm and fault relay control with apb register access
// Function
// [R1] normally-open alarm contact: open without alarm, closed on alarm
// [R2] normally-closed alarm contact: closed without alarm, open on alarm
// [R3] after reset alarm contacts default to normally open
// [R4] open-on-fault: fault contact closed when healthy, open on any fault
// [R5] closed-on-fault: fault contact closed on fault, open otherwise
// [R6] fault contact defaults to open-on-fault without explicit selection
// [R7] separate low and high stages each drive own relay at setpoint
// [R8] switch four down selects non-latching, up selects latching low alarm
// [R9] low alarm defaults to non-latching
// [R10] non-latching low alarm drops when gas falls below low setpoint
// [R11] latching low alarm holds after gas falls until operator clears
// [R12] magnetic switch activation clears a latched low alarm
// [R13] high alarm always latches, no setting changes that
// [R14] high alarm holds after gas falls until operator clears
// [R15] magnetic switch activation clears a latched high alarm
// [R16] operator leaves target gas switches one to three untouched
// [R17] magnetic input synchronised and debounced; clear only below setpoint
// [R18] settings sampled continuously; polarity applied after alarm logic
//
// Design decisions made here: the APB interface to the registers and the register offsets.
module garc_relay_ctrl
  import garc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        low_trip,
  input  wire logic        high_trip,
  input  wire logic        fault_in,
  input  wire logic        alarm_nc_sel,
  input  wire logic        fault_open_sel,
  input  wire logic        fault_closed_sel,
  input  wire logic        low_latch_sw,
  input  wire logic [2:0]  gas_sel,
  input  wire logic        fixed_factory_jumper,
  input  wire logic        magnetic_switch_input,
  output logic             relay_low,
  output logic             relay_high,
  output logic             relay_fault,
  output logic             irq
);

  initial
  begin
    if (DEBOUNCE_CYCLES < 1)
      $error("garc_relay_ctrl: DEBOUNCE_CYCLES must be at least 1");
  end

  typedef struct packed {
    garc_pins_s          meta;
    garc_pins_s          pins;
    logic [CTRL_W-1:0]   ctrl;
    logic                clr_req;
    logic                low_alm;
    logic                high_alm;
    logic                fault;
    logic [EV_W-1:0]     irq_stat;
    logic [EV_W-1:0]     irq_mask;
    garc_relay_s         relay;
    garc_apb_rsp_s       apb;
    logic                irq;
  } garc_state_s;

  garc_state_s q;
  garc_state_s next_q;

  logic mag_level;
  logic mag_press;

  // magnetic key fob input: the debouncer owns its synchroniser
  garc_debounce #(
    .STABLE_CYC (DEBOUNCE_CYCLES)
  ) u_mag (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (magnetic_switch_input),
    .level   (mag_level),
    .press   (mag_press)
  ); // [R17]

  garc_pins_s pins_raw;

  always_comb
  begin
    pins_raw.low_trip             = low_trip;
    pins_raw.high_trip            = high_trip;
    pins_raw.fault_in             = fault_in;
    pins_raw.alarm_nc_sel         = alarm_nc_sel;
    pins_raw.fault_open_sel       = fault_open_sel;
    pins_raw.fault_closed_sel     = fault_closed_sel;
    pins_raw.low_latch_sw         = low_latch_sw;
    pins_raw.gas_sel              = gas_sel;
    pins_raw.fixed_factory_jumper = fixed_factory_jumper;
  end

  // effective configuration, either straps or software override
  logic       cfg_latch;
  logic       cfg_nc;
  logic       cfg_cof;
  logic       jumper_cof;
  logic       jumper_bad;

  always_comb
  begin
    // only a lone closed-on-fault jumper selects the inverted sense;
    // a missing or doubled jumper keeps the safe open-on-fault sense
    jumper_cof = q.pins.fault_closed_sel & ~q.pins.fault_open_sel; // [R6]
    jumper_bad = ~(q.pins.fault_closed_sel ^ q.pins.fault_open_sel);
    if (q.ctrl[CTRL_SW_CFG])
    begin
      cfg_latch = q.ctrl[CTRL_LATCH];
      cfg_nc    = q.ctrl[CTRL_NC];
      cfg_cof   = q.ctrl[CTRL_COF];
    end
    else
    begin
      cfg_latch = q.pins.low_latch_sw; // [R8] [R9]
      cfg_nc    = q.pins.alarm_nc_sel; // [R3]
      cfg_cof   = jumper_cof;          // [R6]
    end
  end

  // apb decode
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [ST_W-1:0] status;

  always_comb
  begin
    setup  = psel & ~penable;
    wr_acc = psel & penable & pready & pwrite;
    mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
             (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
    status                  = '0;
    status[ST_LOW_ALM]      = q.low_alm;
    status[ST_HIGH_ALM]     = q.high_alm;
    status[ST_FAULT]        = q.fault;
    status[ST_LOW_K]        = q.relay.low;
    status[ST_HIGH_K]       = q.relay.high;
    status[ST_FAULT_K]      = q.relay.fault;
    status[ST_LATCH]        = cfg_latch;
    status[ST_NC]           = cfg_nc;
    status[ST_COF]          = cfg_cof;
    status[ST_MAG]          = mag_level;
    status[ST_GAS +: 3]     = q.pins.gas_sel; // [R16]
    case (paddr)
      OFS_CTRL:     rd_mux = {28'h0000000, q.ctrl};
      OFS_STATUS:   rd_mux = {17'h00000, status};
      OFS_IRQ_STAT: rd_mux = {28'h0000000, q.irq_stat};
      OFS_IRQ_MASK: rd_mux = {28'h0000000, q.irq_mask};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // alarm and fault state, before any contact sense is applied
  logic            clear_any;
  logic            next_low;
  logic            next_high;
  logic            next_fault;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;

  always_comb
  begin
    clear_any = mag_press | q.clr_req; // [R12] [R15]
    // a latched stage only clears once gas is below its setpoint
    if (q.pins.low_trip)
      next_low = 1'b1; // [R7]
    else if (!cfg_latch)
      next_low = 1'b0; // [R10]
    else if (clear_any)
      next_low = 1'b0; // [R11] [R12] [R17]
    else
      next_low = q.low_alm; // [R11]
    if (q.pins.high_trip)
      next_high = 1'b1; // [R7]
    else if (clear_any)
      next_high = 1'b0; // [R14] [R15] [R17]
    else
      next_high = q.high_alm; // [R13] [R14]
    next_fault = q.pins.fault_in | ~q.pins.fixed_factory_jumper |
                 (jumper_bad & ~q.ctrl[CTRL_SW_CFG]);
    ev           = '0;
    ev[EV_LOW]   = next_low & ~q.low_alm;
    ev[EV_HIGH]  = next_high & ~q.high_alm;
    ev[EV_FAULT] = next_fault & ~q.fault;
    // only a stage that really drops counts; a clear under gas is no event
    ev[EV_CLEAR] = clear_any & ((q.low_alm & ~next_low) |
                                (q.high_alm & ~next_high));
    w1c = '0;
    if (wr_acc && paddr == OFS_IRQ_STAT)
      w1c = pwdata[EV_W-1:0];
  end

  always_comb
  begin
    next_q      = q;
    next_q.meta = pins_raw;
    next_q.pins = q.meta;
    // clear request is a self-clearing strobe
    next_q.clr_req = 1'b0;
    if (wr_acc && paddr == OFS_CTRL)
    begin
      next_q.ctrl    = pwdata[CTRL_W-1:0];
      next_q.clr_req = pwdata[CTRL_CLEAR];
    end
    if (wr_acc && paddr == OFS_IRQ_MASK)
      next_q.irq_mask = pwdata[EV_W-1:0];
    next_q.low_alm  = next_low;
    next_q.high_alm = next_high;
    next_q.fault    = next_fault;
    // a new event in the clear cycle wins over the clear
    next_q.irq_stat = (q.irq_stat & ~w1c) | ev;
    next_q.irq      = |(next_q.irq_stat & next_q.irq_mask);
    // contact sense applied after the state logic; 1 means closed
    next_q.relay.low   = q.low_alm ^ cfg_nc;     // [R1] [R2] [R18]
    next_q.relay.high  = q.high_alm ^ cfg_nc;    // [R1] [R2] [R18]
    next_q.relay.fault = q.fault ~^ cfg_cof;     // [R4] [R5] [R18]
    // one wait-free access cycle: pready rises in the first access cycle
    next_q.apb.pready  = setup;
    next_q.apb.pslverr = setup & ~mapped;
    next_q.apb.prdata  = (setup && !pwrite) ? rd_mux : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q                    <= '0;
      q.ctrl               <= CTRL_RST;
      q.irq_stat           <= EV_RST;
      q.irq_mask           <= EV_RST;
      // healthy, normally-open reset state: alarm open, fault closed
      q.relay.fault        <= 1'b1; // [R3] [R6]
      q.meta.fixed_factory_jumper <= 1'b1;
      q.pins.fixed_factory_jumper <= 1'b1;
      // straps start at the factory fitting so release shows no false fault
      q.meta.fault_open_sel       <= 1'b1;
      q.pins.fault_open_sel       <= 1'b1;
    end
    else
      q <= next_q;
  end

  assign pready      = q.apb.pready;
  assign pslverr     = q.apb.pslverr;
  assign prdata      = q.apb.prdata;
  assign relay_low   = q.relay.low;
  assign relay_high  = q.relay.high;
  assign relay_fault = q.relay.fault;
  assign irq         = q.irq;

endmodule // garc_relay_ctrl

// *** garc_relay_ctrl_props.sv ***
// checker: relay contact and latch timing seen at the block pins
module garc_relay_ctrl_props
  import garc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic low_trip,
  input wire logic high_trip,
  input wire logic fault_in,
  input wire logic alarm_nc_sel,
  input wire logic fault_open_sel,
  input wire logic fault_closed_sel,
  input wire logic low_latch_sw,
  input wire logic fixed_factory_jumper,
  input wire logic magnetic_switch_input,
  input wire logic relay_low,
  input wire logic relay_high,
  input wire logic relay_fault
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // held counts samples since the switch rose with trips and nc low;
  // a delay range cannot span a field-length debounce time
  logic        mag_q;
  logic [31:0] held;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mag_q <= 1'b0;
      held  <= 32'h00000000;
    end
    else
    begin
      mag_q <= magnetic_switch_input;
      if (!(magnetic_switch_input && !low_trip && !high_trip
            && !alarm_nc_sel))
        held <= 32'h00000000;
      else if ((held != 32'h00000000 || !mag_q) && held != 32'hFFFFFFFF)
        held <= held + 32'h00000001;
    end
  end
  // eight samples: two sync flops, state and relay stage need four edges
  // no bus traffic either: a software clear strobe may drop a latch
  sequence quiet_s;
    (!magnetic_switch_input && !alarm_nc_sel && !psel)[*8];
  endsequence
  sequence press_s;
    held == DEBOUNCE_CYCLES + 5;
  endsequence
  AST_LOW_NO: assert property (
    (low_trip && !alarm_nc_sel)[*6] |-> relay_low)
    else $error("low contact open during alarm");
  AST_LOW_NC: assert property (
    (low_trip && alarm_nc_sel)[*6] |-> !relay_low)
    else $error("low contact closed during alarm");
  AST_HIGH_NO: assert property (
    (high_trip && !alarm_nc_sel)[*6] |-> relay_high)
    else $error("high contact open during alarm");
  AST_FAULT_OPEN: assert property (
    (fault_in && fault_open_sel && !fault_closed_sel)[*6] |-> !relay_fault)
    else $error("fault contact closed on fault");
  AST_FAULT_OK: assert property (
    (!fault_in && fault_open_sel && !fault_closed_sel
      && fixed_factory_jumper)[*6] |-> relay_fault)
    else $error("fault contact open while healthy");
  AST_FAULT_CLOSED: assert property (
    (fault_in && !fault_open_sel && fault_closed_sel)[*6] |-> relay_fault)
    else $error("fault contact open on fault");
  AST_LOW_DROP: assert property (
    (!low_trip && !low_latch_sw && !alarm_nc_sel)[*6] |-> !relay_low)
    else $error("non-latching low alarm stuck");
  AST_LOW_HOLD: assert property (
    (!magnetic_switch_input && !alarm_nc_sel && low_latch_sw && !psel)[*8]
      ##0 relay_low |=> relay_low)
    else $error("latched low alarm dropped");
  AST_HIGH_HOLD: assert property (
    quiet_s ##0 relay_high |=> relay_high)
    else $error("latched high alarm dropped");
  AST_CLEAR: assert property (
    press_s |-> (!relay_low && !relay_high))
    else $error("switch press did not clear alarms");
  AST_APB_READY: assert property (
    (psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("no ready in first access cycle");
endmodule // garc_relay_ctrl_props

bind garc_relay_ctrl garc_relay_ctrl_props #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) i_props (.*);

// *** garc_alarm_panel.sv ***
// partner model: alarm panel wired to the dry relay contacts
module garc_alarm_panel
  import garc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire garc_relay_s contacts,
  input wire logic        nc_wiring,
  output logic            horn,
  output logic            trouble
);
  // panel wiring must follow the contact jumper, else a quiet site sounds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      horn <= 1'b0;
      trouble <= 1'b0;
    end
    else
    begin
      horn <= nc_wiring ? !(contacts.low && contacts.high)
                        : (contacts.low || contacts.high);
      trouble <= !contacts.fault;
    end
  end
endmodule // garc_alarm_panel

// *** testbench.sv ***
// testbench: pin table, latch and clear cases, register access
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
  end
module testbench
  import garc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // row: pin bundle over expected {low, high, fault} contacts
  localparam logic [13:0] ROWS [10] = '{14'h0229, 14'h222D, 14'h262B,
    14'h062F, 14'h0A28, 14'h0929, 14'h0128, 14'h0220, 14'h0328, 14'h0229};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        irq;
  logic        mag;
  logic        horn;
  logic        trouble;
  garc_pins_s  pins;
  wire garc_relay_s rly;
  int          num_errors;
  int          compares;

  garc_relay_ctrl #(
    .DEBOUNCE_CYCLES(4)
  ) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .low_trip(pins.low_trip),
    .high_trip(pins.high_trip), .fault_in(pins.fault_in),
    .alarm_nc_sel(pins.alarm_nc_sel), .fault_open_sel(pins.fault_open_sel),
    .fault_closed_sel(pins.fault_closed_sel),
    .low_latch_sw(pins.low_latch_sw), .gas_sel(pins.gas_sel),
    .fixed_factory_jumper(pins.fixed_factory_jumper),
    .magnetic_switch_input(mag), .relay_low(rly.low),
    .relay_high(rly.high), .relay_fault(rly.fault), .irq(irq)
  );
  garc_alarm_panel i_panel (
    .pclk(pclk), .presetn(presetn), .contacts(rly),
    .nc_wiring(pins.alarm_nc_sel), .horn(horn), .trouble(trouble)
  );

  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // eight edges cover the four-edge pin to contact path
  task automatic put(input garc_pins_s p);
    pins <= p;
    repeat (8) @(posedge pclk);
  endtask
  task automatic press();
    mag <= 1'b1;
    repeat (12) @(posedge pclk);
    mag <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a transfer that never completes
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mag = 1'b0;
    pins = 11'h045;
    num_errors = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    `CHK("reset contacts", 3'h1, rly)
    presetn <= 1'b1;
    foreach (ROWS[i])
    begin
      put(ROWS[i][13:3]);
      `CHK("contacts", ROWS[i][2:0], rly)
    end
    `CHK("panel trouble", 1'b0, trouble)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("gas field", 3'h2, rd[14:12])
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK("events", 4'h5, rd[3:0])
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    `CHK("irq cleared", 1'b0, irq)
    put(11'h245);
    `CHK("high on", 2'h3, {rly.high, horn})
    press();
    `CHK("clear under gas", 1'b1, rly.high)
    put(11'h045);
    `CHK("high held", 1'b1, rly.high)
    press();
    `CHK("high cleared", 1'b0, rly.high)
    put(11'h455);
    put(11'h055);
    `CHK("low held", 1'b1, rly.low)
    press();
    `CHK("low cleared", 1'b0, rly.low)
    // software override: a missing fault jumper is no fault then
    apb(1'b1, OFS_CTRL, 32'h1);
    put(11'h005);
    `CHK("override fault", 1'b1, rly.fault)
    put(11'h205);
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    apb(1'b1, OFS_CTRL, 32'h11);
    repeat (4) @(posedge pclk);
    `CHK("strobe under gas", 1'b1, rly.high)
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK("no clear event", 4'h0, rd[3:0])
    put(11'h005);
    apb(1'b1, OFS_CTRL, 32'h11);
    repeat (4) @(posedge pclk);
    `CHK("strobe clear", 1'b0, rly.high)
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK("clear event", 4'h8, rd[3:0])
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl readback", 32'h1, rd)
    // mid-run reset drops a latch and must not flash the fault contact
    put(11'h245);
    put(11'h045);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("mid reset contacts", 3'h1, rly)
    presetn <= 1'b1;
    repeat (8)
    begin
      @(posedge pclk);
      `CHK("fault after reset", 1'b1, rly.fault)
    end
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK("events after reset", 4'h0, rd[3:0])
    close_out();
  end
endmodule // testbench
